// >>> hdl/pmsi_pkg.sv
/*
 * pmsi_pkg: constants for the power management control/status word and
 * the slot identification capability of a bridge configuration space.
 * Assumes dword-addressed configuration accesses with byte enables.
 */
package pmsi_pkg;
    // --------------------------------------------------------------
    // register offsets (byte addresses of dwords)
    // --------------------------------------------------------------
    localparam logic [7:0] PMSI_OFF_PM_CSR = 8'h94;
    localparam logic [7:0] PMSI_OFF_SLOT_ID = 8'ha0;
    localparam logic [7:0] PMSI_OFF_PM_CAP = 8'h90;
    localparam logic [7:0] PMSI_OFF_SSID = 8'ha8;
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int PMSI_PS_LO = 0;
    localparam int PMSI_PME_EN_BIT = 8;
    localparam int PMSI_PME_ST_BIT = 15;
    localparam int PMSI_SEC_PD_SUP_BIT = 22;
    localparam int PMSI_BPCC_BIT = 23;
    localparam int PMSI_SLOT_LO = 16;
    localparam int PMSI_FIC_BIT = 21;
    localparam int PMSI_CHASSIS_LO = 24;
    localparam int PMSI_CAP_ID_LO = 0;
    localparam int PMSI_NEXT_LO = 8;
    localparam int PMSI_PME_SUP_LO = 27;
    // --------------------------------------------------------------
    // codes and reset values
    // --------------------------------------------------------------
    localparam logic [1:0] PMSI_PS_FULL_ON = 2'h0;
    localparam logic [1:0] PMSI_PS_DEEP_OFF = 2'h3;
    localparam logic [1:0] PMSI_PS_RESET = 2'h0;
    localparam logic [7:0] PMSI_SLOT_CAP_ID = 8'h04;
    localparam logic [7:0] PMSI_SLOT_NEXT = 8'hb0;
    localparam logic [4:0] PMSI_PME_SUPPORT = 5'h19;
    localparam logic [4:0] PMSI_SLOT_RESET = 5'h00;
    localparam logic [7:0] PMSI_CHASSIS_RESET = 8'h00;
    // internal reset pulse length in clocks after leaving deep-off
    localparam logic [3:0] PMSI_DEV_RST_CYCLES = 4'h8;
endpackage

// >>> hdl/pmsi_regs.sv
/*
 * pmsi_regs: power management control/status and slot identification
 * configuration registers.
 * Assumes a single-cycle configuration port (address, byte enables,
 * read and write strobes) synchronous to MCLK, and a sticky reset
 * (AUX_RST) that only power-on asserts.
 */
`timescale 1ns/10ps
module pmsi_regs
    import pmsi_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic AUX_RST,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [31:0] CFG_WDATA,
    output logic [31:0] CFG_RDATA,
    output logic CFG_RVALID,
    input wire logic EE_LOADED,
    input wire logic EE_SLOT_ID_EN,
    input wire logic WAKE_EVENT,
    output logic WAKE_EVENT_OUT_N,
    output logic DEV_RESET,
    output logic [1:0] POWER_STATE,
    output logic SLOT_ID_PRESENT
);
    import pmsi_pkg::*;

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [1:0] ps_reg, ps_next;
    logic [3:0] drst_cnt_reg, drst_cnt_next;
    logic dev_rst_reg, dev_rst_next;
    logic pme_en_reg, pme_en_next;
    logic pme_st_reg, pme_st_next;
    logic wake_n_reg, wake_n_next;
    logic si_en_reg, si_en_next;
    logic [4:0] slot_reg, slot_next;
    logic fic_reg, fic_next;
    logic [7:0] chassis_reg, chassis_next;
    logic [31:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    // --------------------------------------------------------------
    // decoded strobes and read words
    // --------------------------------------------------------------
    logic hit_pm, hit_si, hit_cap;
    logic wr_ps_lane, wr_wake_lane;
    logic wr_slot_lane, wr_chassis_lane;
    logic [1:0] wr_ps;
    logic ps_code_ok, leave_off;
    logic pm_clear_st;
    logic [31:0] pm_word, si_word, cap_word;

    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    // the slot id dword only answers once the EEPROM has switched it on,
    // so a hidden structure neither reads back nor takes writes
    always_comb begin
        hit_pm = 1'b0;
        hit_si = 1'b0;
        hit_cap = 1'b0;
        if (CFG_ADDR == PMSI_OFF_PM_CSR) begin
            hit_pm = 1'b1;
        end else if (CFG_ADDR == PMSI_OFF_SLOT_ID) begin
            hit_si = si_en_reg;
        end else if (CFG_ADDR == PMSI_OFF_PM_CAP) begin
            hit_cap = 1'b1;
        end
        wr_ps_lane = CFG_WR && hit_pm && CFG_BE[0];
        wr_wake_lane = CFG_WR && hit_pm && CFG_BE[1];
        wr_slot_lane = CFG_WR && hit_si && CFG_BE[2];
        wr_chassis_lane = CFG_WR && hit_si && CFG_BE[3];
        wr_ps = CFG_WDATA[PMSI_PS_LO +: 2];
        pm_clear_st = wr_wake_lane && CFG_WDATA[PMSI_PME_ST_BIT];
    end

    // --------------------------------------------------------------
    // power state
    // --------------------------------------------------------------
    always_comb begin
        ps_next = ps_reg;
        // intermediate states are not built: keep the old code
        ps_code_ok = wr_ps == PMSI_PS_FULL_ON ||
            wr_ps == PMSI_PS_DEEP_OFF;
        leave_off = 1'b0;
        if (wr_ps_lane && ps_code_ok) begin
            ps_next = wr_ps;
            // a deep-off to full-on move restarts the internal reset below
            leave_off = ps_reg == PMSI_PS_DEEP_OFF &&
                wr_ps == PMSI_PS_FULL_ON;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ps_reg <= PMSI_PS_RESET;
        end else begin
            ps_reg <= ps_next;
        end
    end

    // --------------------------------------------------------------
    // internal device reset
    // --------------------------------------------------------------
    // the pulse is counted here and registered so that the reset line
    // leaving the block cannot glitch; the bus reset pin is not touched
    always_comb begin
        drst_cnt_next = drst_cnt_reg;
        if (leave_off) begin
            drst_cnt_next = PMSI_DEV_RST_CYCLES;
        end else if (drst_cnt_reg != 4'h0) begin
            drst_cnt_next = drst_cnt_reg - 4'h1;
        end
        dev_rst_next = drst_cnt_next != 4'h0;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            drst_cnt_reg <= 4'h0;
            dev_rst_reg <= 1'b0;
        end else begin
            drst_cnt_reg <= drst_cnt_next;
            dev_rst_reg <= dev_rst_next;
        end
    end

    // --------------------------------------------------------------
    // wake enable (sticky: of the two resets only AUX_RST clears it)
    // --------------------------------------------------------------
    // software may arm the output while a status is already pending;
    // the output then falls on the next edge
    always_comb begin
        pme_en_next = pme_en_reg;
        if (wr_wake_lane) begin
            pme_en_next = CFG_WDATA[PMSI_PME_EN_BIT];
        end
    end

    always_ff @(posedge MCLK) begin
        if (AUX_RST) begin
            pme_en_reg <= 1'b0;
        end else begin
            pme_en_reg <= pme_en_next;
        end
    end

    // --------------------------------------------------------------
    // wake status and wake output (sticky as well)
    // --------------------------------------------------------------
    always_comb begin
        pme_st_next = pme_st_reg;
        if (pm_clear_st) begin
            pme_st_next = 1'b0;
        end
        // a new event wins over a clear in the same cycle, so no event
        // is lost between software reading and clearing the bit
        if (WAKE_EVENT) begin
            pme_st_next = 1'b1;
        end
        // wake allowed in every implemented state (full-on, deep-off)
        wake_n_next = ~(pme_en_next && pme_st_next);
    end

    always_ff @(posedge MCLK) begin
        if (AUX_RST) begin
            pme_st_reg <= 1'b0;
            wake_n_reg <= 1'b1;
        end else begin
            pme_st_reg <= pme_st_next;
            wake_n_reg <= wake_n_next;
        end
    end

    // --------------------------------------------------------------
    // slot identification enable
    // --------------------------------------------------------------
    // the enable follows the EEPROM whenever its image is valid, so a
    // reload can hide the structure again
    always_comb begin
        si_en_next = si_en_reg;
        if (EE_LOADED) begin
            si_en_next = EE_SLOT_ID_EN;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            si_en_reg <= 1'b0;
        end else begin
            si_en_reg <= si_en_next;
        end
    end

    // --------------------------------------------------------------
    // slot number, first-in-chassis and chassis number
    // --------------------------------------------------------------
    // writes land only while the structure is visible
    always_comb begin
        slot_next = slot_reg;
        fic_next = fic_reg;
        chassis_next = chassis_reg;
        if (wr_slot_lane) begin
            slot_next = CFG_WDATA[PMSI_SLOT_LO +: 5];
            fic_next = CFG_WDATA[PMSI_FIC_BIT];
        end
        if (wr_chassis_lane) begin
            chassis_next = CFG_WDATA[PMSI_CHASSIS_LO +: 8];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            slot_reg <= PMSI_SLOT_RESET;
            fic_reg <= 1'b0;
            chassis_reg <= PMSI_CHASSIS_RESET;
        end else begin
            slot_reg <= slot_next;
            fic_reg <= fic_next;
            chassis_reg <= chassis_next;
        end
    end

    // --------------------------------------------------------------
    // read words
    // --------------------------------------------------------------
    // unimplemented fields are never filled in, so they read zero and
    // no write can reach them
    always_comb begin
        pm_word = 32'h0000_0000;
        pm_word[PMSI_PS_LO +: 2] = ps_reg;
        pm_word[PMSI_PME_EN_BIT] = pme_en_reg;
        pm_word[PMSI_PME_ST_BIT] = pme_st_reg;
        pm_word[PMSI_SEC_PD_SUP_BIT] = 1'b0;
        pm_word[PMSI_BPCC_BIT] = 1'b0;
        si_word = 32'h0000_0000;
        si_word[PMSI_CAP_ID_LO +: 8] = PMSI_SLOT_CAP_ID;
        si_word[PMSI_NEXT_LO +: 8] = PMSI_SLOT_NEXT;
        si_word[PMSI_SLOT_LO +: 5] = slot_reg;
        si_word[PMSI_FIC_BIT] = fic_reg;
        si_word[PMSI_CHASSIS_LO +: 8] = chassis_reg;
        cap_word = 32'h0000_0000;
        // only the wake support field of that dword is owned here
        cap_word[PMSI_PME_SUP_LO +: 5] = PMSI_PME_SUPPORT;
    end

    // --------------------------------------------------------------
    // read path
    // --------------------------------------------------------------
    // read data is zero whenever no read is answered, so a stale word
    // never lingers on the return lines
    always_comb begin
        rdata_next = 32'h0000_0000;
        rvalid_next = CFG_RD;
        if (CFG_RD) begin
            if (hit_pm) begin
                rdata_next = pm_word;
            end else if (hit_si) begin
                rdata_next = si_word;
            end else if (hit_cap) begin
                rdata_next = cap_word;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            rdata_reg <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign CFG_RDATA = rdata_reg;
    assign CFG_RVALID = rvalid_reg;
    assign WAKE_EVENT_OUT_N = wake_n_reg;
    assign DEV_RESET = dev_rst_reg;
    assign POWER_STATE = ps_reg;
    assign SLOT_ID_PRESENT = si_en_reg;
endmodule

// >>> verification/pmsi_regs_asserts.sv
/* pmsi_regs_asserts: port-level checks for pmsi_regs.
   Assumes one clock, MCLK, and the active-high RST and AUX_RST resets. */
`timescale 1ns/10ps
module pmsi_regs_asserts (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic AUX_RST,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [31:0] CFG_WDATA,
    input wire logic [31:0] CFG_RDATA,
    input wire logic CFG_RVALID,
    input wire logic WAKE_EVENT,
    input wire logic WAKE_EVENT_OUT_N,
    input wire logic DEV_RESET,
    input wire logic [1:0] POWER_STATE,
    input wire logic SLOT_ID_PRESENT
);
    logic psw;
    assign psw = CFG_WR && CFG_ADDR == 8'h94 && CFG_BE[0];
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST || AUX_RST);
    ps_legal_a: assert property (!(POWER_STATE inside {2'h1, 2'h2}))
        else $error("power state holds an unsupported code");
    ps_write_a: assert property (psw && CFG_WDATA[0] == CFG_WDATA[1]
        |=> POWER_STATE == $past(CFG_WDATA[1:0]))
        else $error("power state write not taken");
    ps_keep_a: assert property (psw && CFG_WDATA[0] != CFG_WDATA[1]
        |=> $stable(POWER_STATE)) else $error("bad power code taken");
    rd_answer_a: assert property (CFG_RD |=> CFG_RVALID)
        else $error("read not answered");
    pm_zero_a: assert property (CFG_RD && CFG_ADDR == 8'h94 |=>
        CFG_RDATA[31:22] == 10'h0 && CFG_RDATA[14:9] == 6'h0)
        else $error("unimplemented power bits not zero");
    dev_rst_a: assert property (!$past(RST) &&
        $past(POWER_STATE) == 2'h3 && POWER_STATE == 2'h0 |->
        DEV_RESET [*8] ##1 !DEV_RESET)
        else $error("internal reset pulse wrong");
    dev_cause_a: assert property ($rose(DEV_RESET) |->
        $past(POWER_STATE) == 2'h3) else $error("stray internal reset");
    wake_cause_a: assert property ($fell(WAKE_EVENT_OUT_N) |->
        $past(WAKE_EVENT) || $past(CFG_WR)) else $error("stray wake");
    slot_hidden_a: assert property (CFG_RD && CFG_ADDR == 8'ha0 &&
        !SLOT_ID_PRESENT |=> CFG_RDATA == 32'h0)
        else $error("hidden slot id readable");
    slot_head_a: assert property (CFG_RD && CFG_ADDR == 8'ha0 &&
        SLOT_ID_PRESENT |=> CFG_RDATA[15:0] == 16'hb004)
        else $error("slot id header wrong");
endmodule
bind pmsi_regs pmsi_regs_asserts u_pmsi_regs_asserts (.MCLK(MCLK),
    .RST(RST), .AUX_RST(AUX_RST), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE),
    .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_WDATA(CFG_WDATA),
    .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
    .WAKE_EVENT(WAKE_EVENT), .WAKE_EVENT_OUT_N(WAKE_EVENT_OUT_N),
    .DEV_RESET(DEV_RESET), .POWER_STATE(POWER_STATE),
    .SLOT_ID_PRESENT(SLOT_ID_PRESENT));

// >>> verification/testbench.sv
/* testbench: register table walk, then internal reset, wake and resets.
   Assumes pmsi_regs with the EEPROM image valid except across one late reset. */
`timescale 1ns/10ps
module testbench;
    logic MCLK = 1'h0, RST = 1'h1, AUX_RST = 1'h1;
    logic [7:0] CFG_ADDR = 8'h0;
    logic [3:0] CFG_BE = 4'h0;
    logic CFG_WR = 1'h0, CFG_RD = 1'h0, WAKE_EVENT = 1'h0;
    logic [31:0] CFG_WDATA = 32'h0, CFG_RDATA;
    logic CFG_RVALID, WAKE_EVENT_OUT_N, DEV_RESET, SLOT_ID_PRESENT;
    logic EE_LOADED = 1'h1, EE_SLOT_ID_EN = 1'h1;
    logic [1:0] POWER_STATE;
    int errors = 0, checked = 0, cycles = 0;
    // rows: address, byte enables, write data, read-back
    logic [75:0] rows [8] = '{
        {8'h94, 4'hf, 32'hffffffff, 32'h00000103},
        {8'h94, 4'h1, 32'h00000001, 32'h00000103},
        {8'h94, 4'h1, 32'h00000002, 32'h00000103},
        {8'h94, 4'h2, 32'h00000000, 32'h00000003},
        {8'ha0, 4'hf, 32'hffffffff, 32'hff3fb004},
        {8'ha0, 4'h4, 32'h00000000, 32'hff00b004},
        {8'h90, 4'hf, 32'hffffffff, 32'hc8000000},
        {8'h9c, 4'hf, 32'hffffffff, 32'h00000000}};
    pmsi_regs u_pmsi_regs (.MCLK(MCLK), .RST(RST), .AUX_RST(AUX_RST),
        .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WR(CFG_WR),
        .CFG_RD(CFG_RD), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
        .CFG_RVALID(CFG_RVALID), .EE_LOADED(EE_LOADED),
        .EE_SLOT_ID_EN(EE_SLOT_ID_EN), .WAKE_EVENT(WAKE_EVENT),
        .WAKE_EVENT_OUT_N(WAKE_EVENT_OUT_N), .DEV_RESET(DEV_RESET),
        .POWER_STATE(POWER_STATE), .SLOT_ID_PRESENT(SLOT_ID_PRESENT));
    initial begin
        forever #4 MCLK = ~MCLK;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
        @(negedge MCLK);
        {CFG_ADDR, CFG_BE, CFG_WDATA, CFG_WR} = {a, b, d, 1'h1};
        @(negedge MCLK);
        CFG_WR = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge MCLK);
        {CFG_ADDR, CFG_RD} = {a, 1'h1};
        @(negedge MCLK);
        CFG_RD = 1'h0;
        chk({31'h0, CFG_RVALID}, 32'h1);
        chk(CFG_RDATA, exp);
    endtask
    task automatic finish_test;
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // a hang in any wait loop is cut short here
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(negedge MCLK);
        {RST, AUX_RST} = 2'h0;
        rd(8'h94, 32'h0);
        rd(8'ha0, 32'h0000b004);
        foreach (rows[i]) begin
            wr(rows[i][75:68], rows[i][67:64], rows[i][63:32]);
            rd(rows[i][75:68], rows[i][31:0]);
        end
        wr(8'h94, 4'h1, 32'h0);
        for (int i = 0; i < 8; i++) begin
            chk({31'h0, DEV_RESET}, 32'h1);
            @(negedge MCLK);
        end
        chk({31'h0, DEV_RESET}, 32'h0);
        chk({30'h0, POWER_STATE}, 32'h0);
        wr(8'h94, 4'h2, 32'h00000100);
        WAKE_EVENT = 1'h1;
        @(negedge MCLK);
        WAKE_EVENT = 1'h0;
        chk({31'h0, WAKE_EVENT_OUT_N}, 32'h0);
        wr(8'h94, 4'h2, 32'h00008100);
        chk({31'h0, WAKE_EVENT_OUT_N}, 32'h1);
        wr(8'h94, 4'h2, 32'h0);
        WAKE_EVENT = 1'h1;
        @(negedge MCLK);
        WAKE_EVENT = 1'h0;
        chk({31'h0, WAKE_EVENT_OUT_N}, 32'h1);
        // ordinary reset must leave the wake status alone
        RST = 1'h1;
        @(negedge MCLK);
        RST = 1'h0;
        rd(8'h94, 32'h00008000);
        rd(8'ha0, 32'h0000b004);
        EE_SLOT_ID_EN = 1'h0;
        repeat (2) @(negedge MCLK);
        rd(8'ha0, 32'h0);
        chk({31'h0, SLOT_ID_PRESENT}, 32'h0);
        // a write to the hidden structure must not land
        wr(8'ha0, 4'hf, 32'hffffffff);
        EE_SLOT_ID_EN = 1'h1;
        @(negedge MCLK);
        chk({31'h0, SLOT_ID_PRESENT}, 32'h1);
        rd(8'ha0, 32'h0000b004);
        // with no EEPROM image the structure stays hidden after reset
        EE_LOADED = 1'h0;
        RST = 1'h1;
        @(negedge MCLK);
        RST = 1'h0;
        @(negedge MCLK);
        chk({31'h0, SLOT_ID_PRESENT}, 32'h0);
        EE_LOADED = 1'h1;
        @(negedge MCLK);
        chk({31'h0, SLOT_ID_PRESENT}, 32'h1);
        AUX_RST = 1'h1;
        @(negedge MCLK);
        AUX_RST = 1'h0;
        rd(8'h94, 32'h0);
        finish_test();
    end
endmodule
